/* File: rtl/rpc_pkg.sv */
// constants for the ram pointer and configuration register bank
// assumes a 32-bit apb slave with byte addresses and one word per register
package rpc_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_PTR_HIGH = 8'h00;
  localparam logic [7:0] OFF_PTR_LOW = 8'h04;
  localparam logic [7:0] OFF_SELECT = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0C;

  // pointer high register fields
  localparam int PH_DIR_BIT = 7;
  localparam int PH_STEP_BIT = 6;
  localparam int PH_ADDR_MSB = 2;

  // configuration register fields
  localparam int CFG_SRST_BIT = 7;
  localparam int CFG_CHAIN_BIT = 6;
  localparam int CFG_MISC_MSB = 5;
  localparam int CFG_MISC_LSB = 2;

  // widths
  localparam int RAM_ADDR_W = 11;
  localparam int SEL_W = 3;

  // values after reset
  localparam logic [10:0] PTR_RESET = 11'h000;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // indirect select codes at the shared address
  localparam logic [2:0] SEL_TENTATIVE_ID = 3'h0;
  localparam logic [2:0] SEL_NODE_ID = 3'h1;
  localparam logic [2:0] SEL_SETUP_1 = 3'h2;
  localparam logic [2:0] SEL_NEXT_ID = 3'h3;
  localparam logic [2:0] SEL_SETUP_2 = 3'h4;

  // register decode result
  typedef enum logic [2:0] {
    RPC_REG_PTR_HIGH,
    RPC_REG_PTR_LOW,
    RPC_REG_SELECT,
    RPC_REG_CONFIG,
    RPC_REG_NONE
  } rpc_reg_t;

endpackage

/* File: rtl/rpc_ptr_if.sv */
// carrier between the register bank and its ram pointer counter
// assumes both ends share pclk and presetn
`timescale 1ns/100ps
interface rpc_ptr_if;
  logic load_high;
  logic load_low;
  logic [7:0] wdata;
  logic step;
  logic [10:0] addr;

  modport ctrl (output load_high, output load_low, output wdata, output step, input addr);
  modport cnt (input load_high, input load_low, input wdata, input step, output addr);
endinterface

/* File: rtl/rpc_ptr_counter.sv */
// eleven bit ram address pointer with byte loads and single step
// assumes load strobes and step are one-cycle pulses in the pclk domain
`timescale 1ns/100ps
module rpc_ptr_counter (
  input wire logic pclk,
  input wire logic presetn,
  rpc_ptr_if.cnt ptr
);

  logic [10:0] addr;

  // software loads win over a step in the same cycle, so a reload is never lost
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr <= rpc_pkg::PTR_RESET;
    end
    else if (ptr.load_high || ptr.load_low)
    begin
      if (ptr.load_high)
      begin
        addr[10:8] <= ptr.wdata[rpc_pkg::PH_ADDR_MSB:0];
      end
      if (ptr.load_low)
      begin
        addr[7:0] <= ptr.wdata;
      end
    end
    else if (ptr.step)
    begin
      addr <= addr + 11'h001; // low byte carry runs into the top bits
    end
  end

  assign ptr.addr = addr;

endmodule

/* File: rtl/rpc_regs.sv */
// ram pointer, indirect select and configuration registers behind apb
// assumes a zero-wait apb master on pclk; the ram datapath pulses
// ram_access_done once per completed data access
`timescale 1ns/100ps

// Operation
// - pointer high bit 7 picks read or write
// - bit 6 steps pointer after each access
// - pointer high bits 2-0 give address 10-8
// - pointer low byte gives address 7-0
// - three-bit select routes the shared address
// - low select bits shared with configuration register
// - configuration write clears select top bit
// - config bit 7 holds software reset until cleared
// - software reset keeps interface mode and configuration
// - software reset only clears status, next id, diagnostics
// - reserved pointer and select bits have no function
module rpc_regs #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ram_access_done,
  output logic [10:0] ram_addr,
  output logic access_direction_read,
  output logic pointer_step_enable,
  output logic [2:0] indirect_select,
  output logic tentative_id_sel,
  output logic node_id_sel,
  output logic setup_1_sel,
  output logic next_id_sel,
  output logic setup_2_sel,
  output logic chained_commands_on,
  output logic [3:0] config_misc,
  output logic soft_reset
);

  // decode of a bus address into a register, shared by read and write
  function automatic rpc_pkg::rpc_reg_t rpc_decode(input logic [ADDR_W-1:0] a);
    logic [7:0] lo;
    lo = a[7:0];
    if ((a >> 8) != '0)
    begin
      rpc_decode = rpc_pkg::RPC_REG_NONE;
    end
    else if (lo == rpc_pkg::OFF_PTR_HIGH)
    begin
      rpc_decode = rpc_pkg::RPC_REG_PTR_HIGH;
    end
    else if (lo == rpc_pkg::OFF_PTR_LOW)
    begin
      rpc_decode = rpc_pkg::RPC_REG_PTR_LOW;
    end
    else if (lo == rpc_pkg::OFF_SELECT)
    begin
      rpc_decode = rpc_pkg::RPC_REG_SELECT;
    end
    else if (lo == rpc_pkg::OFF_CONFIG)
    begin
      rpc_decode = rpc_pkg::RPC_REG_CONFIG;
    end
    else
    begin
      rpc_decode = rpc_pkg::RPC_REG_NONE;
    end
  endfunction

  // register state, one group of flops per field
  logic dir_read;
  logic step_on;
  logic sel_msb;
  logic [1:0] sel_low;
  logic [2:0] sel;
  logic srst_bit;
  logic chain_bit;
  logic [3:0] misc_bits;

  // bus phase terms
  rpc_pkg::rpc_reg_t hit;
  logic setup_phase;
  logic access_phase;
  logic write_take;
  logic wr_lane0;
  logic [7:0] wbyte;
  logic wr_ptr_high;
  logic wr_ptr_low;
  logic wr_select;
  logic wr_config;

  // read views and decoded select
  logic [7:0] next_ptr_high_rd;
  logic [7:0] next_ptr_low_rd;
  logic [7:0] next_select_rd;
  logic [7:0] next_config_rd;
  logic [7:0] next_rd_byte;
  logic [4:0] sel_hot;

  // select codes of the five targets behind the shared indirect address
  localparam logic [2:0] SEL_TARGET [5] = '{rpc_pkg::SEL_TENTATIVE_ID, rpc_pkg::SEL_NODE_ID,
    rpc_pkg::SEL_SETUP_1, rpc_pkg::SEL_NEXT_ID, rpc_pkg::SEL_SETUP_2};

  // match of a select code against one target;
  // reserved codes 5..7 match none, so nothing is routed for them
  function automatic logic sel_match(input logic [2:0] code, input logic [2:0] target);
    sel_match = (code == target);
  endfunction

  rpc_ptr_if ptr ();

  // pointer counter lives in its own module so the carry chain stays local
  rpc_ptr_counter u_ptr (
    .pclk (pclk),
    .presetn (presetn),
    .ptr (ptr)
  );

  // apb: always ready, unmapped addresses answer with an error;
  // zero wait keeps the host loop short at the cost of a setup-time read
  assign hit = rpc_decode(paddr);
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access_phase && (hit == rpc_pkg::RPC_REG_NONE);

  // a write lands only at the access edge on a mapped address
  assign write_take = access_phase && pwrite && (hit != rpc_pkg::RPC_REG_NONE);
  assign wr_lane0 = write_take && pstrb[0]; // registers sit in byte lane 0
  assign wbyte = pwdata[7:0];

  // one write strobe per register; a clear lane 0 strobe leaves all alone
  assign wr_ptr_high = wr_lane0 && (hit == rpc_pkg::RPC_REG_PTR_HIGH);
  assign wr_ptr_low = wr_lane0 && (hit == rpc_pkg::RPC_REG_PTR_LOW);
  assign wr_select = wr_lane0 && (hit == rpc_pkg::RPC_REG_SELECT);
  assign wr_config = wr_lane0 && (hit == rpc_pkg::RPC_REG_CONFIG);

  // pointer loads and steps towards the counter
  assign ptr.load_high = wr_ptr_high;
  assign ptr.load_low = wr_ptr_low;
  assign ptr.wdata = wbyte;
  assign ptr.step = ram_access_done && step_on;

  // direction of the next ram access;
  // the ram datapath reads it level-wise, so no pulse is needed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_read <= 1'b0;
    end
    else if (wr_ptr_high)
    begin
      dir_read <= wbyte[rpc_pkg::PH_DIR_BIT];
    end
  end

  // auto step enable;
  // a new value only affects accesses completed after this write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      step_on <= 1'b0;
    end
    else if (wr_ptr_high)
    begin
      step_on <= wbyte[rpc_pkg::PH_STEP_BIT];
    end
  end

  // low select bits: one set of flops behind both register views
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_low <= rpc_pkg::SEL_RESET[1:0];
    end
    else if (wr_select || wr_config)
    begin
      sel_low <= wbyte[1:0];
    end
  end

  // top select bit; upper bits of a select write are dropped
  // a config write cannot reach code 4, so it forces the bit low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_msb <= rpc_pkg::SEL_RESET[2];
    end
    else if (wr_select)
    begin
      sel_msb <= wbyte[2];
    end
    else if (wr_config)
    begin
      sel_msb <= 1'b0;
    end
  end

  // software reset bit; the reset it raises never reaches this bank
  // it stays set until software writes a zero, there is no self clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      srst_bit <= rpc_pkg::CFG_RESET[rpc_pkg::CFG_SRST_BIT];
    end
    else if (wr_config)
    begin
      srst_bit <= wbyte[rpc_pkg::CFG_SRST_BIT];
    end
  end

  // command chaining enable;
  // low keeps the older one-command-at-a-time behaviour
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chain_bit <= rpc_pkg::CFG_RESET[rpc_pkg::CFG_CHAIN_BIT];
    end
    else if (wr_config)
    begin
      chain_bit <= wbyte[rpc_pkg::CFG_CHAIN_BIT];
    end
  end

  // remaining configuration fields, only stored and exported here;
  // kept through a software reset like the rest of the register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      misc_bits <= rpc_pkg::CFG_RESET[rpc_pkg::CFG_MISC_MSB:rpc_pkg::CFG_MISC_LSB];
    end
    else if (wr_config)
    begin
      misc_bits <= wbyte[rpc_pkg::CFG_MISC_MSB:rpc_pkg::CFG_MISC_LSB];
    end
  end

  // select code as seen by the rest of the device
  assign sel = {sel_msb, sel_low};

  // pointer high view; reserved bits 5..3 read as zero
  always_comb
  begin
    next_ptr_high_rd = 8'h00;
    next_ptr_high_rd[rpc_pkg::PH_DIR_BIT] = dir_read;
    next_ptr_high_rd[rpc_pkg::PH_STEP_BIT] = step_on;
    next_ptr_high_rd[rpc_pkg::PH_ADDR_MSB:0] = ptr.addr[10:8];
  end

  // pointer low view straight from the counter
  always_comb
  begin
    next_ptr_low_rd = ptr.addr[7:0];
  end

  // select view; reserved bits 7..3 read as zero
  always_comb
  begin
    next_select_rd = 8'h00;
    next_select_rd[2:0] = sel;
  end

  // configuration view with the shared select bits at the bottom
  always_comb
  begin
    next_config_rd = 8'h00;
    next_config_rd[rpc_pkg::CFG_SRST_BIT] = srst_bit;
    next_config_rd[rpc_pkg::CFG_CHAIN_BIT] = chain_bit;
    next_config_rd[rpc_pkg::CFG_MISC_MSB:rpc_pkg::CFG_MISC_LSB] = misc_bits;
    next_config_rd[1:0] = sel_low; // shared storage read back
  end

  // read data mux by decoded register;
  // unmapped reads give zero alongside the error response
  always_comb
  begin
    case (hit)
      rpc_pkg::RPC_REG_PTR_HIGH: next_rd_byte = next_ptr_high_rd;
      rpc_pkg::RPC_REG_PTR_LOW: next_rd_byte = next_ptr_low_rd;
      rpc_pkg::RPC_REG_SELECT: next_rd_byte = next_select_rd;
      rpc_pkg::RPC_REG_CONFIG: next_rd_byte = next_config_rd;
      default: next_rd_byte = 8'h00;
    endcase
  end

  // read data captured in the setup cycle so prdata comes from a flop;
  // a pointer step between setup and access is not seen by that read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= rpc_pkg::RDATA_RESET;
    end
    else if (setup_phase && !pwrite)
    begin
      prdata <= {24'h00_0000, next_rd_byte};
    end
  end

  // one decoder per target at the shared indirect address;
  // at most one is high, none for a reserved code
  genvar k;
  generate
    for (k = 0; k < 5; k++)
    begin : g_sel
      assign sel_hot[k] = sel_match(sel, SEL_TARGET[k]);
    end
  endgenerate

  // ram pointer and access controls
  assign ram_addr = ptr.addr;
  assign access_direction_read = dir_read;
  assign pointer_step_enable = step_on;

  // select routing at the shared indirect address
  assign indirect_select = sel;
  assign tentative_id_sel = sel_hot[0];
  assign node_id_sel = sel_hot[1];
  assign setup_1_sel = sel_hot[2];
  assign next_id_sel = sel_hot[3];
  assign setup_2_sel = sel_hot[4];

  // configuration outputs
  assign chained_commands_on = chain_bit;
  assign config_misc = misc_bits;

  // soft reset level lasts until software writes the bit back to zero;
  // only status, next id and diagnostic blocks listen to it
  assign soft_reset = srst_bit;

endmodule

/* File: tb/rpc_regs_sva.sv */
// assertions on the ports of the register bank
// assumes one pclk domain, bound to every rpc_regs
`timescale 1ns/100ps
module rpc_regs_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic ram_access_done,
  input wire logic [10:0] ram_addr,
  input wire logic access_direction_read,
  input wire logic pointer_step_enable,
  input wire logic [2:0] indirect_select,
  input wire logic tentative_id_sel,
  input wire logic node_id_sel,
  input wire logic setup_1_sel,
  input wire logic next_id_sel,
  input wire logic setup_2_sel,
  input wire logic chained_commands_on,
  input wire logic soft_reset
);
  logic wr;
  // write as the bank takes it; only a pointer high or low write blocks a pointer step
  assign wr = psel & penable & pwrite & pstrb[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  dir_load_a: assert property (
    wr && paddr == rpc_pkg::OFF_PTR_HIGH |=> access_direction_read == $past(pwdata[7]))
    else $error("direction not loaded");
  high_load_a: assert property (
    wr && paddr == rpc_pkg::OFF_PTR_HIGH |=> ram_addr[10:8] == $past(pwdata[2:0]))
    else $error("upper address not loaded");
  low_load_a: assert property (
    wr && paddr == rpc_pkg::OFF_PTR_LOW |=> ram_addr[7:0] == $past(pwdata[7:0]))
    else $error("lower address not loaded");
  step_add_a: assert property (
    ram_access_done && pointer_step_enable && !wr |=> ram_addr == 11'($past(ram_addr) + 11'h001))
    else $error("pointer did not step");
  step_hold_a: assert property (
    !pointer_step_enable && !wr |=> $stable(ram_addr))
    else $error("pointer moved");
  sel_decode_a: assert property (
    {setup_2_sel, next_id_sel, setup_1_sel, node_id_sel, tentative_id_sel}
      == 5'(6'h01 << indirect_select))
    else $error("select decode wrong");
  cfg_sel_a: assert property (
    wr && paddr == rpc_pkg::OFF_CONFIG |=> indirect_select == {1'b0, $past(pwdata[1:0])})
    else $error("select not set by config");
  srst_load_a: assert property (
    wr && paddr == rpc_pkg::OFF_CONFIG |=> soft_reset == $past(pwdata[7]))
    else $error("soft reset bit wrong");
  chain_load_a: assert property (
    wr && paddr == rpc_pkg::OFF_CONFIG |=> chained_commands_on == $past(pwdata[6]))
    else $error("chaining bit wrong");
  sel_write_a: assert property (
    wr && paddr == rpc_pkg::OFF_SELECT |=> indirect_select == $past(pwdata[2:0]))
    else $error("select not set by write");
endmodule
bind rpc_regs rpc_regs_sva #(.ADDR_W(ADDR_W)) u_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .ram_access_done, .ram_addr, .access_direction_read,
  .pointer_step_enable, .indirect_select, .tentative_id_sel, .node_id_sel, .setup_1_sel,
  .next_id_sel, .setup_2_sel, .chained_commands_on, .soft_reset);

/* File: tb/ram_pointer_and_config_regs_bench.sv */
// self-checking bench for the pointer and configuration registers
// assumes rpc_regs with a zero-wait apb slave
`timescale 1ns/100ps
module ram_pointer_and_config_regs_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ram_access_done;
  logic access_direction_read, pointer_step_enable, chained_commands_on, soft_reset;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb, config_misc;
  logic [10:0] ram_addr;
  logic [2:0] indirect_select;
  logic [4:0] sel;
  int n_mismatch, n_tests;
  typedef struct {logic [7:0] wa; logic [7:0] wd; logic [7:0] ra; logic [7:0] ex;} rpc_row_t;
  // write one place, read back there or at another; reserved bits read zero
  rpc_row_t rows [5] = '{'{rpc_pkg::OFF_PTR_HIGH, 8'hFF, rpc_pkg::OFF_PTR_HIGH, 8'hC7},
    '{rpc_pkg::OFF_PTR_LOW, 8'hA5, rpc_pkg::OFF_PTR_LOW, 8'hA5},
    '{rpc_pkg::OFF_SELECT, 8'hFC, rpc_pkg::OFF_SELECT, 8'h04},
    '{rpc_pkg::OFF_CONFIG, 8'h7E, rpc_pkg::OFF_SELECT, 8'h02},
    '{rpc_pkg::OFF_SELECT, 8'h07, rpc_pkg::OFF_CONFIG, 8'h7F}};
  rpc_regs #(.ADDR_W(8)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .ram_access_done, .ram_addr, .access_direction_read,
    .pointer_step_enable, .indirect_select, .tentative_id_sel(sel[0]), .node_id_sel(sel[1]),
    .setup_1_sel(sel[2]), .next_id_sel(sel[3]), .setup_2_sel(sel[4]), .chained_commands_on,
    .config_misc, .soft_reset);
  // 25 MHz clock
  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // waits an edge first so no signal is driven twice in one time step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  // one ram access pulse, then time for the pointer to show it
  task automatic step();
    @(posedge pclk);
    ram_access_done <= 1;
    @(posedge pclk);
    ram_access_done <= 0;
    @(posedge pclk);
    #1;
  endtask
  task automatic test_done();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the hundred or so cycles the run needs
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    test_done();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, ram_access_done, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1;
    #1 chk(sel, 32'h01);
    foreach (rows[i])
    begin
      apb(1, rows[i].wa, 32'(rows[i].wd));
      apb(0, rows[i].ra, 32'h0);
      chk(r, 32'(rows[i].ex));
    end
    for (int c = 0; c < 8; c++)
    begin
      apb(1, rpc_pkg::OFF_SELECT, 32'(c));
      chk(sel, (c < 5) ? 32'(1 << c) : 32'h0);
    end
    // carry out of the low byte, then wrap at the top
    apb(1, rpc_pkg::OFF_PTR_HIGH, 32'h42);
    apb(1, rpc_pkg::OFF_PTR_LOW, 32'hFF);
    step();
    chk(ram_addr, 32'h300);
    apb(1, rpc_pkg::OFF_PTR_HIGH, 32'h47);
    apb(1, rpc_pkg::OFF_PTR_LOW, 32'hFF);
    step();
    chk(ram_addr, 32'h0);
    apb(1, rpc_pkg::OFF_PTR_HIGH, 32'h83);
    step();
    chk(ram_addr, 32'h300);
    chk(access_direction_read, 32'h1);
    chk(pointer_step_enable, 32'h0);
    apb(1, rpc_pkg::OFF_CONFIG, 32'hC4);
    chk(indirect_select, 32'h0);
    chk(soft_reset, 32'h1);
    chk(chained_commands_on, 32'h1);
    apb(0, rpc_pkg::OFF_CONFIG, 32'h0);
    chk(r, 32'hC4);
    chk(config_misc, 32'h1);
    chk(ram_addr, 32'h300);
    apb(1, rpc_pkg::OFF_CONFIG, 32'h0);
    chk(soft_reset, 32'h0);
    apb(1, 8'h10, 32'hFF);
    chk(e, 32'h1);
    // a write with lane 0 strobe clear must leave the pointer alone
    @(posedge pclk);
    pstrb <= 4'hE;
    apb(1, rpc_pkg::OFF_PTR_LOW, 32'h55);
    chk(ram_addr, 32'h300);
    @(posedge pclk);
    pstrb <= 4'hF;
    // reset in mid-run with soft reset and pointer set
    apb(1, rpc_pkg::OFF_CONFIG, 32'hC4);
    apb(1, rpc_pkg::OFF_PTR_HIGH, 32'hC5);
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    #1 chk(ram_addr, 32'h0);
    chk(access_direction_read, 32'h0);
    chk(soft_reset, 32'h0);
    chk(chained_commands_on, 32'h0);
    chk(sel, 32'h01);
    @(posedge pclk);
    presetn <= 1;
    apb(0, rpc_pkg::OFF_PTR_HIGH, 32'h0);
    chk(r, 32'h0);
    test_done();
  end
endmodule
